// ### dv/hdlc_stats_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Checks the reply handshake and busy flag at the block's ports.
module hdlc_stats_chk #(
  parameter int LINKS = 4,
  parameter int FREE_W = 8,
  parameter int BUSY_THRESHOLD = 4,
  parameter int LW = (LINKS > 1) ? $clog2(LINKS) : 1
) (
  input wire logic clk, // Clock.
  input wire logic srst, // Reset.
  input wire logic [LINKS*FREE_W-1:0] free_buffers, // Free counts.
  input wire logic req_valid, // Request.
  input wire logic [LW-1:0] req_link, // Link.
  input wire logic req_ready, // Idle.
  input wire logic reply_valid, // Word offered.
  input wire logic reply_ready, // Word taken.
  input wire logic [7:0] reply_offset, // Offset.
  input wire logic [31:0] reply_data, // Data.
  input wire logic reply_last, // Last word.
  input wire logic [LINKS-1:0] busy_status // Busy flags.
);
  // One domain, so clock and reset are stated once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_start;
    req_valid && req_ready |=>
      reply_valid && !req_ready && reply_offset == 8'h00;
  endproperty
  a_start: assert property (p_start) else $error("no reply start");
  property p_hold;
    reply_valid && !reply_ready |=>
      reply_valid && $stable(reply_data) && $stable(reply_offset);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved");
  property p_step;
    reply_valid && reply_ready && !reply_last |=>
      reply_valid && reply_offset == $past(reply_offset) + 8'h04;
  endproperty
  a_step: assert property (p_step) else $error("bad offset step");
  property p_last;
    reply_valid |-> reply_last == (reply_offset == 8'h2C) && !req_ready;
  endproperty
  a_last: assert property (p_last) else $error("bad last flag");
  property p_end;
    reply_valid && reply_ready && reply_last |=> !reply_valid && req_ready;
  endproperty
  a_end: assert property (p_end) else $error("reply not closed");
  property p_zero;
    reply_valid && (reply_offset == 8'h0C || reply_offset == 8'h2C) |->
      reply_data == 32'h0000_0000;
  endproperty
  a_zero: assert property (p_zero) else $error("reserved not 0");
  // Link 0 busy follows its free count one cycle late, below the threshold.
  property p_busy;
    !$past(srst) |-> busy_status[0] ==
      ($past(free_buffers[FREE_W-1:0]) < BUSY_THRESHOLD);
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag wrong");
  property p_flag;
    reply_valid && reply_offset == 8'h28 |-> reply_data[31:1] == 31'h0;
  endproperty
  a_flag: assert property (p_flag) else $error("busy word wide");
  // An unmapped link gives all-zero reply data for the 8 cycles after the take.
  property p_unmapped;
    req_valid && req_ready && req_link >= LINKS |=>
      (reply_data == 32'h0000_0000) [*8];
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
endmodule // hdlc_stats_chk
bind hdlc_link_statistics_counters hdlc_stats_chk #(.LINKS(LINKS),
  .FREE_W(FREE_W), .BUSY_THRESHOLD(BUSY_THRESHOLD)) chk_i (.clk(clk),
  .srst(srst), .free_buffers(free_buffers), .req_valid(req_valid),
  .req_link(req_link), .req_ready(req_ready), .reply_valid(reply_valid),
  .reply_ready(reply_ready), .reply_offset(reply_offset),
  .reply_data(reply_data), .reply_last(reply_last),
  .busy_status(busy_status));
`default_nettype wire

// ### dv/host_requester.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: offers one request and gathers its twelve reply words.
module host_requester #(parameter int LW = 2) (
  input wire logic clk, // Clock.
  input wire logic start, // Pulse: offer a request.
  input wire logic [LW-1:0] link, // Link wanted.
  input wire logic [7:0] status, // Clear request.
  input wire logic slow, // Take words every other cycle.
  input wire logic req_ready, // Block idle.
  input wire logic reply_valid, // Word offered.
  input wire logic reply_last, // Final word.
  input wire logic [7:0] reply_offset, // Word offset.
  input wire logic [31:0] reply_data, // Word data.
  output logic req_valid, // Held until taken.
  output logic [LW-1:0] req_link, // Link sent.
  output logic [7:0] req_status, // Status sent.
  output logic reply_ready, // Word accepted.
  output logic done, // Pulse after the final word.
  output logic [31:0] words [12] // Gathered reply.
);
  // Start quiet so nothing is offered during reset.
  initial begin
    req_valid = 1'b0;
    req_link = '0;
    req_status = 8'h00;
    reply_ready = 1'b0;
    done = 1'b0;
  end
  // Idle lines show the inverse so a stale value is never trusted.
  always @(posedge clk) begin
    done <= 1'b0;
    if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      req_link <= ~req_link;
      req_status <= ~req_status;
    end else if (start) begin
      req_valid <= 1'b1;
      req_link <= link;
      req_status <= status;
    end
    if (reply_valid && reply_ready) begin
      words[reply_offset[5:2]] <= reply_data;
      done <= reply_last;
    end
    reply_ready <= slow ? ~reply_ready : 1'b1;
  end
endmodule // host_requester
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Reads link statistics through the host model after known traffic.
module tb_top;
  localparam int LINKS = 3; // Link code 3 stays unmapped.
  localparam int LW = 2;
  localparam int TENTH = 10; // Short tick so elapsed time moves.
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [LINKS-1:0] abort_seen = '0, check_fail = '0, length_bad = '0;
  logic [LINKS-1:0] no_buffer_discard = '0, frame_good = '0;
  logic [LINKS-1:0] frame_kept = '0, frame_sent = '0;
  logic [LINKS-1:0] frame_auto_repeat = '0, busy_status;
  logic [23:0] free_buffers = {LINKS{8'h0A}};
  logic req_valid, req_ready, reply_valid, reply_ready, reply_last, done;
  logic start = 1'b0, slow = 1'b0;
  logic [LW-1:0] req_link, h_link = '0;
  logic [7:0] req_status, reply_offset, h_status = 8'h00;
  logic [31:0] reply_data;
  logic [31:0] words [12];
  int errors = 0, check_count = 0, cyc = 0, snap_ab = 0, snap_el = 0;
  int tally [LINKS] = '{default: 0}; // Aborts since the last clear.
  int clr [LINKS] = '{default: 0}; // Cycle of the last clear.
  always #50 clk = ~clk;
  hdlc_link_statistics_counters #(.LINKS(LINKS), .FREE_W(8),
    .BUSY_THRESHOLD(4), .TENTH_CYCLES(TENTH)) uut (.clk(clk), .srst(srst),
    .abort_seen(abort_seen), .check_fail(check_fail),
    .length_bad(length_bad), .no_buffer_discard(no_buffer_discard),
    .free_buffers(free_buffers), .frame_good(frame_good),
    .frame_kept(frame_kept), .frame_sent(frame_sent),
    .frame_auto_repeat(frame_auto_repeat), .req_valid(req_valid),
    .req_link(req_link), .req_status(req_status), .req_ready(req_ready),
    .reply_valid(reply_valid), .reply_ready(reply_ready),
    .reply_offset(reply_offset), .reply_data(reply_data),
    .reply_last(reply_last), .busy_status(busy_status));
  host_requester #(.LW(LW)) host (.clk(clk), .start(start), .link(h_link),
    .status(h_status), .slow(slow), .req_ready(req_ready),
    .reply_valid(reply_valid), .reply_last(reply_last),
    .reply_offset(reply_offset), .reply_data(reply_data),
    .req_valid(req_valid), .req_link(req_link), .req_status(req_status),
    .reply_ready(reply_ready), .done(done), .words(words));
  // Own abort tally; a clearing take keeps that same cycle's event.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
    for (int l = 0; l < LINKS; l++) begin
      if (srst || (req_valid && req_ready && req_link == l)) begin
        snap_ab = tally[l];
        snap_el = (cyc - clr[l]) / TENTH;
      end
      if (srst || (req_valid && req_ready && req_link == l && req_status))
        clr[l] = cyc;
      tally[l] = (clr[l] == cyc) ? 0 : tally[l];
      tally[l] = tally[l] + (srst ? 0 : int'(abort_seen[l]));
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Runs one request through the host and waits, bounded, for its end.
  task automatic rd(input logic [LW-1:0] lk, input logic [7:0] st,
                    input logic sl);
    int n;
    h_link <= lk;
    h_status <= st;
    slow <= sl;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("reply done", 32'h1, 32'(done));
  endtask
  task automatic cmp(input int ck, ln, ds, be, fi, un, tx, cg);
    chk("elapsed", 32'h1, 32'(words[0] + 1 >= snap_el &&
        words[0] <= snap_el + 1));
    chk("abort", snap_ab, words[1]);
    chk("check", ck, words[2]);
    chk("reserved", 32'h0, words[3]);
    chk("length", ln, words[4]);
    chk("discard", ds, words[5]);
    chk("busy entry", be, words[6]);
    chk("filtered", fi, words[7]);
    chk("unfiltered", un, words[8]);
    chk("transmit", tx, words[9]);
    chk("busy word", cg, words[10]);
    chk("pad", 32'h0, words[11]);
  endtask
  // One event kind on link 1, pulsed n times with gaps.
  task automatic fire(input int kind, input int n);
    repeat (n) begin
      case (kind)
        0: abort_seen[1] <= 1'b1;
        1: check_fail[1] <= 1'b1;
        2: length_bad[1] <= 1'b1;
        3: {frame_good[1], frame_kept[1]} <= 2'h3;
        4: frame_good[1] <= 1'b1;
        5: frame_sent[1] <= 1'b1;
        default: {frame_sent[1], frame_auto_repeat[1]} <= 2'h3;
      endcase
      @(posedge clk);
      {abort_seen[1], check_fail[1], length_bad[1]} <= 3'h0;
      {frame_good[1], frame_kept[1]} <= 2'h0;
      {frame_sent[1], frame_auto_repeat[1]} <= 2'h0;
      @(posedge clk);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Traffic on link 1, reads of every link, clears, and a clear mid-event.
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(2'd0, 8'h00, 1'b0);
    cmp(0, 0, 0, 0, 0, 0, 0, 0);
    for (int k = 0; k < 7; k++) fire(k, 3 - k % 2);
    repeat (2) begin
      no_buffer_discard[1] <= 1'b1;
      repeat (3) @(posedge clk);
      no_buffer_discard[1] <= 1'b0;
      @(posedge clk);
    end
    free_buffers[15:8] <= 8'h04;
    repeat (3) @(posedge clk);
    chk("busy at threshold", 32'h0, 32'(busy_status[1]));
    free_buffers[15:8] <= 8'h03;
    repeat (3) @(posedge clk);
    chk("busy below", 32'h1, 32'(busy_status[1]));
    rd(2'd1, 8'h00, 1'b1);
    cmp(2, 3, 2, 1, 2, 5, 2, 1);
    rd(2'd3, 8'h01, 1'b0);
    for (int i = 0; i < 12; i++) chk("unmapped", 32'h0, words[i]);
    rd(2'd0, 8'h00, 1'b0);
    cmp(0, 0, 0, 0, 0, 0, 0, 0);
    rd(2'd1, 8'h01, 1'b0);
    cmp(2, 3, 2, 1, 2, 5, 2, 1);
    free_buffers[15:8] <= 8'h0A;
    repeat (3) @(posedge clk);
    rd(2'd1, 8'h00, 1'b0);
    cmp(0, 0, 0, 0, 0, 0, 0, 0);
    abort_seen[2] <= 1'b1;
    rd(2'd2, 8'h01, 1'b0);
    abort_seen[2] <= 1'b0;
    repeat (40) @(posedge clk);
    rd(2'd2, 8'h00, 1'b0);
    cmp(0, 0, 0, 0, 0, 0, 0, 0);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire

// ### verilog/hdlc_link_statistics_counters.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1 - Each link has its own counter set.
// RL2 - Word zero counts tenths since clear.
// RL3 - Non-zero status: reply, then clear link.
// RL4 - Requester sends status zero or one.
// RL5 - Count each received abort sequence.
// RL6 - Count each frame failing check sequence.
// RL7 - Count frames too long or short.
// RL8 - Count no-buffer discard episodes, not frames.
// RL9 - Busy below threshold; count each entry.
// RL10 - Busy status word reads one while busy.
// RL11 - Count good frames kept by filter.
// RL12 - Count all good frames before filter.
// RL13 - Count sent frames except automatic repeats.
// RL14 - Reserved word at offset 12 reads zero.
// RL15 - Clear is atomic; no event is lost.
module hdlc_link_statistics_counters #(
  parameter int LINKS = 4,
  parameter int FREE_W = 8,
  parameter int BUSY_THRESHOLD = 4,
  parameter int TENTH_CYCLES = hdlc_stats_pkg::TENTH_CYCLES,
  // Width of the link number, needed by the port list below.
  localparam int LW = (LINKS > 1) ? $clog2(LINKS) : 1
) (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [LINKS-1:0] abort_seen, // Abort received, pulse.
  input wire logic [LINKS-1:0] check_fail, // Check sequence bad, pulse.
  input wire logic [LINKS-1:0] length_bad, // Length out of range, pulse.
  input wire logic [LINKS-1:0] no_buffer_discard, // Discarding, level.
  input wire logic [LINKS*FREE_W-1:0] free_buffers, // Free buffers.
  input wire logic [LINKS-1:0] frame_good, // Good frame, pre-filter.
  input wire logic [LINKS-1:0] frame_kept, // Good frame, post-filter.
  input wire logic [LINKS-1:0] frame_sent, // Frame transmitted, pulse.
  input wire logic [LINKS-1:0] frame_auto_repeat, // Sent one is repeat.
  input wire logic req_valid, // Statistics request offered.
  input wire logic [LW-1:0] req_link, // Link addressed.
  input wire logic [7:0] req_status, // Zero reads, non-zero also clears.
  output logic req_ready, // Request can be taken.
  output logic reply_valid, // Reply word on reply_data.
  input wire logic reply_ready, // Reply word accepted.
  output logic [7:0] reply_offset, // Byte offset of the word.
  output logic [31:0] reply_data, // Reply word.
  output logic reply_last, // Final word of the reply.
  output logic [LINKS-1:0] busy_status // Receiver busy per link.
);
  // Width of the tenth-second prescaler.
  localparam int PW = (TENTH_CYCLES > 1) ? $clog2(TENTH_CYCLES) : 1;
  // Last prescaler value before the tick.
  localparam logic [PW-1:0] TICK_LAST = PW'(TENTH_CYCLES - 1);
  // Index of the last reply word.
  localparam logic [3:0] LAST_WORD = 4'(hdlc_stats_pkg::REPLY_WORDS - 1);

  // Refuse configurations the logic cannot serve.
  if (LINKS < 1 || TENTH_CYCLES < 1 || FREE_W < 1) begin : g_bad_size
    $error("Link count, tick period and buffer width must be positive.");
  end
  if (BUSY_THRESHOLD < 1 || BUSY_THRESHOLD > (1 << FREE_W))
  begin : g_bad_threshold
    $error("Busy threshold must fit the free buffer count.");
  end

  // Maps a reply word to the counter slot that feeds it.
  function automatic logic [3:0] word_source(input logic [3:0] w);
    logic [3:0] s;
    s = hdlc_stats_pkg::SLOT_ZERO;
    case (w)
      4'h0: s = hdlc_stats_pkg::SLOT_ELAPSED;
      4'h1: s = hdlc_stats_pkg::SLOT_ABORT;
      4'h2: s = hdlc_stats_pkg::SLOT_CHECK;
      4'h3: s = hdlc_stats_pkg::SLOT_ZERO;
      4'h4: s = hdlc_stats_pkg::SLOT_LENGTH;
      4'h5: s = hdlc_stats_pkg::SLOT_DISCARD;
      4'h6: s = hdlc_stats_pkg::SLOT_BUSY_ENTRY;
      4'h7: s = hdlc_stats_pkg::SLOT_FILTERED;
      4'h8: s = hdlc_stats_pkg::SLOT_UNFILTERED;
      4'h9: s = hdlc_stats_pkg::SLOT_TRANSMIT;
      4'hA: s = hdlc_stats_pkg::SLOT_CONGESTED;
      default: s = hdlc_stats_pkg::SLOT_ZERO;
    endcase
    return s;
  endfunction

  // Byte offset of a reply word from its index.
  function automatic logic [7:0] word_offset(input logic [3:0] w);
    return {2'h0, w, 2'h0};
  endfunction

  // Carrier between this module and the link banks.
  stats_bus_if #(.LINKS(LINKS)) bus ();

  // Tenth-second prescaler shared by all links.
  logic [PW-1:0] prescale;
  // Pulse one cycle per tenth of a second.
  logic tick;
  // Previous discard level, for episode detection.
  logic [LINKS-1:0] discard_seen;
  // Busy condition computed from the free buffer counts.
  logic [LINKS-1:0] busy_now;
  // Request sequencer state.
  hdlc_stats_pkg::req_state_t state;
  // Word index being offered.
  logic [3:0] word;
  // Snapshot of the addressed link, taken in the accept cycle.
  logic [31:0] snap [hdlc_stats_pkg::REPLY_WORDS];
  // Snapshot value assembled from the live counters.
  logic [31:0] next_snap [hdlc_stats_pkg::REPLY_WORDS];
  // Request accepted in this cycle.
  logic take;
  // Addressed link exists.
  logic link_ok;
  // Reply word handed over in this cycle.
  logic word_done;

  // A phase offset of up to one tenth remains after a clear, because the
  // prescaler is shared; one per link would cost a counter per link.
  // RL2 tenth-second tick.
  always_ff @(posedge clk) begin
    if (srst) begin
      prescale <= '0;
      tick <= 1'b0;
    end else if (prescale == TICK_LAST) begin
      prescale <= '0;
      tick <= 1'b1;
    end else begin
      prescale <= prescale + PW'(1);
      tick <= 1'b0;
    end
  end

  // Busy is a plain comparison against the fixed threshold.
  always_comb begin
    for (int i = 0; i < LINKS; i++) begin
      // RL9 busy threshold.
      busy_now[i] = int'(free_buffers[i*FREE_W +: FREE_W]) < BUSY_THRESHOLD;
    end
  end

  // Remember the last busy and discard levels to find rising edges.
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_status <= '0;
      discard_seen <= '0;
    end else begin
      // RL10 busy status flag.
      busy_status <= busy_now;
      discard_seen <= no_buffer_discard;
    end
  end

  // Event conditioning feeding the banks.
  assign bus.tick = tick;
  // RL5 abort count.
  assign bus.ev_abort = abort_seen;
  // RL6 check errors.
  assign bus.ev_check = check_fail;
  // RL7 length errors.
  assign bus.ev_length = length_bad;
  // RL8 episode not frames.
  assign bus.ev_discard = no_buffer_discard & ~discard_seen;
  // RL9 busy entry edge.
  assign bus.ev_busy = busy_now & ~busy_status;
  // RL11 filtered good frames.
  assign bus.ev_filtered = frame_kept;
  // RL12 pre-filter good frames.
  assign bus.ev_unfiltered = frame_good;
  // RL13 repeats excluded.
  assign bus.ev_transmit = frame_sent & ~frame_auto_repeat;

  // One counter bank per link keeps the sets independent.
  for (genvar g = 0; g < LINKS; g++) begin : g_link
    // RL1 independent link sets.
    link_counter_bank #(.LINK(g), .LINKS(LINKS)) u_bank (
      .clk(clk),
      .srst(srst),
      .bus(bus)
    );
  end

  // Request handshake terms.
  assign take = (state == hdlc_stats_pkg::ST_IDLE) && req_valid && req_ready;
  assign link_ok = int'(req_link) < LINKS;
  assign word_done = reply_valid && reply_ready;

  // Clear the addressed link in the accept cycle itself, so the snapshot
  // holds the old values and anything later lands in the fresh counts.
  always_comb begin
    bus.clear = '0;
    // RL3 clear on status.
    if (take && link_ok && (req_status != 8'h00)) begin
      bus.clear[req_link] = 1'b1;
    end
  end

  // Assemble the reply from the live counters of the addressed link.
  always_comb begin
    for (int w = 0; w < hdlc_stats_pkg::REPLY_WORDS; w++) begin
      // RL14 reserved reads zero.
      next_snap[w] = hdlc_stats_pkg::RESERVED_VALUE;
      if (link_ok) begin
        case (word_source(4'(w)))
          // RL10 status word.
          hdlc_stats_pkg::SLOT_CONGESTED: begin
            next_snap[w] = {31'h0000_0000, busy_status[req_link]};
          end
          hdlc_stats_pkg::SLOT_ZERO: begin
            next_snap[w] = hdlc_stats_pkg::RESERVED_VALUE;
          end
          default: begin
            next_snap[w] = bus.count[req_link][word_source(4'(w))];
          end
        endcase
      end
    end
  end

  // Request sequencer: accept, then hand out the words in offset order.
  // The snapshot is frozen, so a slow reader never sees a torn reply.
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= hdlc_stats_pkg::ST_IDLE;
      req_ready <= 1'b0;
      word <= 4'h0;
    end else begin
      case (state)
        hdlc_stats_pkg::ST_IDLE: begin
          if (take) begin
            // RL3 read then clear.
            state <= hdlc_stats_pkg::ST_SEND;
            req_ready <= 1'b0;
            word <= 4'h0;
          end else begin
            req_ready <= 1'b1;
          end
        end
        hdlc_stats_pkg::ST_SEND: begin
          if (word_done) begin
            if (word == LAST_WORD) begin
              state <= hdlc_stats_pkg::ST_IDLE;
              req_ready <= 1'b1;
              word <= 4'h0;
            end else begin
              word <= word + 4'h1;
            end
          end
        end
        default: begin
          state <= hdlc_stats_pkg::ST_IDLE;
          req_ready <= 1'b0;
          word <= 4'h0;
        end
      endcase
    end
  end

  // Snapshot store, loaded only when a request is accepted.
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int w = 0; w < hdlc_stats_pkg::REPLY_WORDS; w++) begin
        snap[w] <= hdlc_stats_pkg::COUNT_RESET;
      end
    end else if (take) begin
      // RL15 atomic snapshot.
      for (int w = 0; w < hdlc_stats_pkg::REPLY_WORDS; w++) begin
        snap[w] <= next_snap[w];
      end
    end
  end

  // Reply output registers; a word holds until reply_ready takes it.
  always_ff @(posedge clk) begin
    if (srst) begin
      reply_valid <= 1'b0;
      reply_offset <= 8'h00;
      reply_data <= 32'h0000_0000;
      reply_last <= 1'b0;
    end else if (take) begin
      // RL2 elapsed word first.
      reply_valid <= 1'b1;
      reply_offset <= hdlc_stats_pkg::OFS_ELAPSED;
      reply_data <= next_snap[0];
      reply_last <= 1'b0;
    end else if (word_done) begin
      if (word == LAST_WORD) begin
        reply_valid <= 1'b0;
        reply_offset <= 8'h00;
        reply_data <= 32'h0000_0000;
        reply_last <= 1'b0;
      end else begin
        reply_offset <= word_offset(word + 4'h1);
        reply_data <= snap[word + 4'h1];
        reply_last <= (word + 4'h1) == LAST_WORD;
      end
    end
  end

endmodule // hdlc_link_statistics_counters
`default_nettype wire

// ### verilog/hdlc_stats_pkg.sv
`default_nettype none
// Shared layout, reset values and timing for the link statistics block.
package hdlc_stats_pkg;
  // Every field of the reply is one 32-bit word.
  localparam int WORD_W = 32;
  // The reply parameter area is 48 bytes, so 12 words.
  localparam int REPLY_WORDS = 12;
  // Byte offsets of the reply words.
  localparam logic [7:0] OFS_ELAPSED = 8'h00;
  localparam logic [7:0] OFS_ABORT = 8'h04;
  localparam logic [7:0] OFS_CHECK = 8'h08;
  localparam logic [7:0] OFS_RESERVED = 8'h0C;
  localparam logic [7:0] OFS_LENGTH = 8'h10;
  localparam logic [7:0] OFS_DISCARD = 8'h14;
  localparam logic [7:0] OFS_BUSY_ENTRY = 8'h18;
  localparam logic [7:0] OFS_FILTERED = 8'h1C;
  localparam logic [7:0] OFS_UNFILTERED = 8'h20;
  localparam logic [7:0] OFS_TRANSMIT = 8'h24;
  localparam logic [7:0] OFS_CONGESTED = 8'h28;
  localparam logic [7:0] OFS_PAD = 8'h2C;
  // Counter slots held by each link bank, in reply order.
  localparam int SLOTS = 9;
  localparam logic [3:0] SLOT_ELAPSED = 4'h0;
  localparam logic [3:0] SLOT_ABORT = 4'h1;
  localparam logic [3:0] SLOT_CHECK = 4'h2;
  localparam logic [3:0] SLOT_LENGTH = 4'h3;
  localparam logic [3:0] SLOT_DISCARD = 4'h4;
  localparam logic [3:0] SLOT_BUSY_ENTRY = 4'h5;
  localparam logic [3:0] SLOT_FILTERED = 4'h6;
  localparam logic [3:0] SLOT_UNFILTERED = 4'h7;
  localparam logic [3:0] SLOT_TRANSMIT = 4'h8;
  // Pseudo slots for words that do not come from a counter.
  localparam logic [3:0] SLOT_CONGESTED = 4'hE;
  localparam logic [3:0] SLOT_ZERO = 4'hF;
  // Reset value of every counter; a clear loads zero plus that cycle's event.
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  // Value returned in the reserved and padding words.
  localparam logic [31:0] RESERVED_VALUE = 32'h0000_0000;
  // Elapsed-time unit is one tenth of a second.
  localparam longint TENTH_NS = 100000000;
  localparam longint CLK_PERIOD_NS = 100;
  localparam int TENTH_CYCLES = int'(TENTH_NS / CLK_PERIOD_NS);
  // Request sequencer states.
  typedef enum {ST_IDLE, ST_SEND} req_state_t;
endpackage
`default_nettype wire

// ### verilog/link_counter_bank.sv
`timescale 1ns/1ps
`default_nettype none
// One link's counters; each slot is an independent 32-bit counter.
module link_counter_bank #(
  parameter int LINK = 0,
  parameter int LINKS = 4
) (
  input wire logic clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  stats_bus_if.bank bus // Events in, counts out.
);
  // Increment requests of this link, one bit per slot.
  logic [hdlc_stats_pkg::SLOTS-1:0] step;
  // Counter storage.
  logic [31:0] cnt [hdlc_stats_pkg::SLOTS];

  // Gather this link's events in slot order.
  assign step = {bus.ev_transmit[LINK], bus.ev_unfiltered[LINK],
                 bus.ev_filtered[LINK], bus.ev_busy[LINK],
                 bus.ev_discard[LINK], bus.ev_length[LINK],
                 bus.ev_check[LINK], bus.ev_abort[LINK], bus.tick};

  for (genvar k = 0; k < hdlc_stats_pkg::SLOTS; k++) begin : g_slot
    // Counters wrap silently at 2^32; software takes differences.
    always_ff @(posedge clk) begin
      if (srst) begin
        cnt[k] <= hdlc_stats_pkg::COUNT_RESET;
      // RL15 clear keeps event: the event of the clear cycle counts.
      end else if (bus.clear[LINK]) begin
        cnt[k] <= {31'h0000_0000, step[k]};
      end else if (step[k]) begin
        // RL1 per-link counting.
        cnt[k] <= cnt[k] + 32'h0000_0001;
      end
    end
    // Expose the count to the request side.
    assign bus.count[LINK][k] = cnt[k];
  end
endmodule // link_counter_bank
`default_nettype wire

// ### verilog/stats_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries conditioned events down to the link banks and counts back up.
interface stats_bus_if #(parameter int LINKS = 4);
  logic tick; // One-cycle pulse every tenth of a second.
  logic [LINKS-1:0] clear; // One-cycle clear per link.
  logic [LINKS-1:0] ev_abort; // Abort sequence seen.
  logic [LINKS-1:0] ev_check; // Check sequence failed.
  logic [LINKS-1:0] ev_length; // Frame too long or too short.
  logic [LINKS-1:0] ev_discard; // Start of a no-buffer discard episode.
  logic [LINKS-1:0] ev_busy; // Entry into the busy state.
  logic [LINKS-1:0] ev_filtered; // Good frame kept by the filter.
  logic [LINKS-1:0] ev_unfiltered; // Good frame before the filter.
  logic [LINKS-1:0] ev_transmit; // Frame sent, repeats excluded.
  logic [31:0] count [LINKS][hdlc_stats_pkg::SLOTS]; // Live counters.
  modport feed(output tick, clear, ev_abort, ev_check, ev_length,
               ev_discard, ev_busy, ev_filtered, ev_unfiltered,
               ev_transmit, input count);
  modport bank(input tick, clear, ev_abort, ev_check, ev_length,
               ev_discard, ev_busy, ev_filtered, ev_unfiltered,
               ev_transmit, output count);
endinterface // stats_bus_if
`default_nettype wire
